// file: core/eil_pkg.sv
// Constants, register map and types for the external interrupt line controller
// Functional notes
// - Filter select bit 1 routes the line through the glitch filter, 0 bypasses it.
// - override_mode_on set enters test mode; cleared returns lines to pad input.
// - In test mode each detector, NMI too, sees the override bit, not the pad.
// - Sync bypass bit 0 adds the sync stage; bit 1 detects without it.
// - Keypad scan runs only while sweep_on is 1, idle otherwise.
// - Scan step period is 2 to the power sweep_prescale plus one rc periods.
// - active_sweep_index shows the driven scan pin; writes to it are ignored.
// - Writing 1 to a line arm bit enables the line; 0 leaves it.
// - Writing 1 to the NMI arm bit enables the NMI; 0 does nothing.
// - Writing 1 to an unarm bit disables that line, NMI included; 0 nothing.
// - Armed state register reads 1 per enabled line, 0 per disabled line.
// - Nine lines; maskable lines in bits 7 to 0, NMI in bit 8.
// - Mode bit 1 selects level detection, 0 selects edge detection.
// - Edge mode: edge bit 1 rising edge, 0 falling edge.
// - Level mode: level bit 1 high level, 0 low level.
// - Detected event sets pending bit; only writing 1 to clear register clears it.
package eil_pkg;
    localparam int NUM_LINES = 9;
    localparam int NMI_BIT = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_PENDING = 8'h0c;
    localparam logic [7:0] OFF_CLEAR = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;
    localparam logic [7:0] OFF_EDGE = 8'h18;
    localparam logic [7:0] OFF_LEVEL = 8'h1c;
    localparam logic [7:0] OFF_FILTER = 8'h20;
    localparam logic [7:0] OFF_OVERRIDE = 8'h24;
    localparam logic [7:0] OFF_SYNC_BYPASS = 8'h28;
    localparam logic [7:0] OFF_SWEEP = 8'h2c;
    localparam logic [7:0] OFF_ARM = 8'h30;
    localparam logic [7:0] OFF_UNARM = 8'h34;
    localparam logic [7:0] OFF_ARMED = 8'h38;
    localparam int OVERRIDE_ON_POS = 31;
    localparam int SWEEP_ON_POS = 0;
    localparam int SWEEP_PRESCALE_LSB = 8;
    localparam int SWEEP_PRESCALE_W = 5;
    localparam int INDEX_LSB = 24;
    localparam int INDEX_W = 3;
    localparam logic [8:0] LINE_RESET = 9'h000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam int FILTER_LEN = 3;
    localparam int RC_DIV = 1;
    localparam int SCAN_CNT_W = 33;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_RUN = 2'b10
    } eil_scan_state_type;
endpackage : eil_pkg

// file: core/eil_ctrl.sv
// External interrupt line controller with keypad scan engine and register port
`timescale 1ns/10ps
module eil_ctrl #(
    parameter int FILTER_LEN = eil_pkg::FILTER_LEN,
    parameter int RC_DIV = eil_pkg::RC_DIV
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [eil_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic [7:0] ext_line_n_i,
    input wire logic nonmaskable_line_i,
    output logic [7:0] scan_pins_o,
    output logic irq_o
);
    localparam int NL = eil_pkg::NUM_LINES;

    function automatic logic hit(input logic [eil_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_mode, wr_edge, wr_level, wr_filter, wr_ovr, wr_byp, wr_sweep;
    logic wr_arm, wr_unarm, wr_clear;
    assign wr_mode = wr_i && hit(addr_i, eil_pkg::OFF_MODE);
    assign wr_edge = wr_i && hit(addr_i, eil_pkg::OFF_EDGE);
    assign wr_level = wr_i && hit(addr_i, eil_pkg::OFF_LEVEL);
    assign wr_filter = wr_i && hit(addr_i, eil_pkg::OFF_FILTER);
    assign wr_ovr = wr_i && hit(addr_i, eil_pkg::OFF_OVERRIDE);
    assign wr_byp = wr_i && hit(addr_i, eil_pkg::OFF_SYNC_BYPASS);
    assign wr_sweep = wr_i && hit(addr_i, eil_pkg::OFF_SWEEP);
    assign wr_arm = wr_i && hit(addr_i, eil_pkg::OFF_ARM);
    assign wr_unarm = wr_i && hit(addr_i, eil_pkg::OFF_UNARM);
    assign wr_clear = wr_i && hit(addr_i, eil_pkg::OFF_CLEAR);

    // Configuration registers
    logic [NL-1:0] mode_sel, edge_sel, level_sel, filter_sel, pad_override_value;
    logic [NL-1:0] sync_bypass_select;
    logic override_mode_on;
    logic sweep_on;
    logic [eil_pkg::SWEEP_PRESCALE_W-1:0] sweep_prescale;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_sel <= eil_pkg::LINE_RESET;
            edge_sel <= eil_pkg::LINE_RESET;
            level_sel <= eil_pkg::LINE_RESET;
            filter_sel <= eil_pkg::LINE_RESET;
            pad_override_value <= eil_pkg::LINE_RESET;
            sync_bypass_select <= eil_pkg::LINE_RESET;
            override_mode_on <= 1'b0;
            sweep_on <= 1'b0;
            sweep_prescale <= 5'h00;
        end else begin
            if (wr_mode) begin
                mode_sel <= wr_data_i[NL-1:0];
            end
            if (wr_edge) begin
                edge_sel <= wr_data_i[NL-1:0];
            end
            if (wr_level) begin
                level_sel <= wr_data_i[NL-1:0];
            end
            if (wr_filter) begin
                filter_sel <= wr_data_i[NL-1:0];
            end
            if (wr_ovr) begin
                pad_override_value <= wr_data_i[NL-1:0];
                override_mode_on <= wr_data_i[eil_pkg::OVERRIDE_ON_POS];
            end
            if (wr_byp) begin
                sync_bypass_select <= wr_data_i[NL-1:0];
            end
            if (wr_sweep) begin
                sweep_on <= wr_data_i[eil_pkg::SWEEP_ON_POS];
                sweep_prescale <= wr_data_i[eil_pkg::SWEEP_PRESCALE_LSB +: eil_pkg::SWEEP_PRESCALE_W];
            end
        end
    end

    // Arm state
    logic [NL-1:0] armed;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            armed <= eil_pkg::LINE_RESET;
        end else if (wr_arm) begin
            armed <= armed | wr_data_i[NL-1:0];
        end else if (wr_unarm) begin
            armed <= armed & ~wr_data_i[NL-1:0];
        end
    end

    // Pad synchronisers: change accepted once second and third stage agree
    logic [NL-1:0] pad_raw, pad_s1, pad_s2, pad_s3, pad_q;
    assign pad_raw = {nonmaskable_line_i, ext_line_n_i};
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pad_s1 <= eil_pkg::LINE_RESET;
            pad_s2 <= eil_pkg::LINE_RESET;
            pad_s3 <= eil_pkg::LINE_RESET;
            pad_q <= eil_pkg::LINE_RESET;
        end else begin
            pad_s1 <= pad_raw;
            pad_s2 <= pad_s1;
            pad_s3 <= pad_s2;
            pad_q <= (pad_s2 & pad_s3) | (pad_q & (pad_s2 ^ pad_s3));
        end
    end

    // Line source, filter, sync stage, detector
    logic [NL-1:0] line_src, filt_q, post_filt, sync_q, det_in, det_prev, event_hit;
    assign line_src = override_mode_on ? pad_override_value : pad_q;
    assign post_filt = filter_sel & filt_q | ~filter_sel & line_src;
    assign det_in = sync_bypass_select & post_filt | ~sync_bypass_select & sync_q;

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_line
            logic [7:0] stable_cnt;
            always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    stable_cnt <= 8'h00;
                    filt_q[g] <= 1'b0;
                end else if (line_src[g] == filt_q[g]) begin
                    stable_cnt <= 8'h00;
                end else if (stable_cnt >= 8'(FILTER_LEN - 1)) begin
                    stable_cnt <= 8'h00;
                    filt_q[g] <= line_src[g];
                end else begin
                    stable_cnt <= stable_cnt + 8'h01;
                end
            end
            always_comb begin
                if (mode_sel[g]) begin
                    event_hit[g] = (det_in[g] == level_sel[g]);
                end else if (edge_sel[g]) begin
                    event_hit[g] = det_in[g] & ~det_prev[g];
                end else begin
                    event_hit[g] = ~det_in[g] & det_prev[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_q <= eil_pkg::LINE_RESET;
            det_prev <= eil_pkg::LINE_RESET;
        end else begin
            sync_q <= post_filt;
            det_prev <= det_in;
        end
    end

    // Pending flags: set wins over clear
    logic [NL-1:0] pending_flags, clear_bits;
    assign clear_bits = wr_clear ? wr_data_i[NL-1:0] : eil_pkg::LINE_RESET;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_flags <= eil_pkg::LINE_RESET;
        end else begin
            pending_flags <= (pending_flags & ~clear_bits) | event_hit;
        end
    end

    assign irq_o = |(pending_flags & armed);

    // Keypad scan engine
    eil_pkg::eil_scan_state_type scan_state;
    logic [7:0] rc_cnt;
    logic rc_tick;
    logic [eil_pkg::SCAN_CNT_W-1:0] scan_cnt, scan_limit;
    logic scan_step;
    logic [eil_pkg::INDEX_W-1:0] active_sweep_index;
    logic [5:0] shift_amt;

    assign shift_amt = {1'b0, sweep_prescale} + 6'h01;
    assign scan_limit = (33'h000000001 << shift_amt) - 33'h000000001;
    assign rc_tick = (rc_cnt >= 8'(RC_DIV - 1));
    assign scan_step = (scan_state == eil_pkg::SCAN_RUN) && rc_tick && (scan_cnt == scan_limit);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_state <= eil_pkg::SCAN_IDLE;
            rc_cnt <= 8'h00;
            scan_cnt <= 33'h000000000;
            active_sweep_index <= 3'h0;
        end else begin
            case (scan_state)
                eil_pkg::SCAN_IDLE: begin
                    rc_cnt <= 8'h00;
                    scan_cnt <= 33'h000000000;
                    active_sweep_index <= 3'h0;
                    if (sweep_on) begin
                        scan_state <= eil_pkg::SCAN_RUN;
                    end
                end
                eil_pkg::SCAN_RUN: begin
                    if (!sweep_on) begin
                        scan_state <= eil_pkg::SCAN_IDLE;
                    end
                    rc_cnt <= rc_tick ? 8'h00 : rc_cnt + 8'h01;
                    if (rc_tick) begin
                        scan_cnt <= (scan_cnt >= scan_limit) ? 33'h000000000
                                                            : scan_cnt + 33'h000000001;
                    end
                    if (scan_step) begin
                        active_sweep_index <= active_sweep_index + 3'h1;
                    end
                end
                default: begin
                    scan_state <= eil_pkg::SCAN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_pins_o <= 8'h00;
        end else if (scan_state == eil_pkg::SCAN_RUN) begin
            scan_pins_o <= 8'h01 << active_sweep_index;
        end else begin
            scan_pins_o <= 8'h00;
        end
    end

    // Register read port, data one cycle after the strobe
    logic [31:0] next_rd_data;
    always_comb begin
        next_rd_data = eil_pkg::DATA_RESET;
        case (addr_i)
            eil_pkg::OFF_PENDING: next_rd_data[NL-1:0] = pending_flags;
            eil_pkg::OFF_MODE: next_rd_data[NL-1:0] = mode_sel;
            eil_pkg::OFF_EDGE: next_rd_data[NL-1:0] = edge_sel;
            eil_pkg::OFF_LEVEL: next_rd_data[NL-1:0] = level_sel;
            eil_pkg::OFF_FILTER: next_rd_data[NL-1:0] = filter_sel;
            eil_pkg::OFF_OVERRIDE: begin
                next_rd_data[NL-1:0] = pad_override_value;
                next_rd_data[eil_pkg::OVERRIDE_ON_POS] = override_mode_on;
            end
            eil_pkg::OFF_SYNC_BYPASS: next_rd_data[NL-1:0] = sync_bypass_select;
            eil_pkg::OFF_SWEEP: begin
                next_rd_data[eil_pkg::SWEEP_ON_POS] = sweep_on;
                next_rd_data[eil_pkg::SWEEP_PRESCALE_LSB +: eil_pkg::SWEEP_PRESCALE_W] = sweep_prescale;
                next_rd_data[eil_pkg::INDEX_LSB +: eil_pkg::INDEX_W] = active_sweep_index;
            end
            eil_pkg::OFF_ARMED: next_rd_data[NL-1:0] = armed;
            default: next_rd_data = eil_pkg::DATA_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= eil_pkg::DATA_RESET;
        end else if (rd_i) begin
            rd_data_o <= next_rd_data;
        end else begin
            rd_data_o <= eil_pkg::DATA_RESET;
        end
    end

    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Arm state and read port
    AST_ARM_SETS: assert property (
        wr_arm |=> ((armed & $past(wr_data_i[NL-1:0])) == $past(wr_data_i[NL-1:0])))
        else $error("Arm write did not enable the line");
    AST_NMI_ARM: assert property (
        wr_arm && !wr_data_i[eil_pkg::NMI_BIT]
        |=> armed[eil_pkg::NMI_BIT] == $past(armed[eil_pkg::NMI_BIT]))
        else $error("Zero in NMI arm bit changed its state");
    AST_UNARM_CLEARS: assert property (
        wr_unarm |=> ((armed & $past(wr_data_i[NL-1:0])) == 9'h000)
        && ((armed | $past(wr_data_i[NL-1:0])) == ($past(armed) | $past(wr_data_i[NL-1:0]))))
        else $error("Unarm write gave wrong armed state");
    AST_ARM_STEADY: assert property (
        !wr_arm && !wr_unarm |=> armed == $past(armed))
        else $error("Armed state moved without a write");
    AST_ARMED_READ: assert property (
        rd_i && addr_i == eil_pkg::OFF_ARMED |=> rd_data_o == {23'h000000, $past(armed)})
        else $error("Armed state read back wrong");
    AST_RD_UPPER: assert property (
        rd_i |=> rd_data_o[23:13] == 11'h000)
        else $error("Unused read bits not zero");

    // Pending flags and interrupt
    AST_PENDING_HOLDS: assert property (
        pending_flags[0] && !(wr_clear && wr_data_i[0]) |=> pending_flags[0])
        else $error("Pending flag dropped without a clear");
    AST_PEND_SET: assert property (
        event_hit != 9'h000 |=> (pending_flags & $past(event_hit)) == $past(event_hit))
        else $error("Event did not set its pending flag");
    AST_PEND_CLEAR: assert property (
        wr_clear && wr_data_i[0] && !event_hit[0] |=> !pending_flags[0])
        else $error("Clear write left the pending flag set");
    AST_PEND_STAY_CLEAR: assert property (
        !pending_flags[0] && !event_hit[0] |=> !pending_flags[0])
        else $error("Pending flag set without an event");
    AST_IRQ_NMI: assert property (
        pending_flags[eil_pkg::NMI_BIT] && armed[eil_pkg::NMI_BIT] |-> irq_o)
        else $error("Armed NMI pending without interrupt");

    // Line source, filter and sync stage
    AST_OVERRIDE_FEEDS: assert property (
        override_mode_on && !filter_sel[0] && sync_bypass_select[0] |-> det_in[0] == pad_override_value[0])
        else $error("Override value did not reach the detector");
    AST_OVERRIDE_NMI: assert property (
        override_mode_on && $past(override_mode_on) && !filter_sel[8] && !$past(filter_sel[8])
        && !sync_bypass_select[8] |-> det_in[8] == $past(pad_override_value[8]))
        else $error("Override value did not reach the NMI detector");
    AST_OVERRIDE_OFF: assert property (
        wr_ovr && !wr_data_i[eil_pkg::OVERRIDE_ON_POS] |=> !override_mode_on && line_src == pad_q)
        else $error("Lines not back on pads after test mode");
    AST_SYNC_DELAY: assert property (
        !sync_bypass_select[0] |-> det_in[0] == $past(post_filt[0]))
        else $error("Sync stage missing on a synchronised line");
    AST_FILTER_CHANGE: assert property (
        $changed(filt_q[0])
        |-> $past(line_src[0], 1) == filt_q[0] && $past(line_src[0], 2) == filt_q[0])
        else $error("Filter passed a short pulse");
    AST_FILTER_STEADY: assert property (
        filter_sel[3] && line_src[3] == filt_q[3] |=> filt_q[3] == $past(filt_q[3]))
        else $error("Filter output moved on a steady input");
    AST_FILTER_LONG: assert property (
        FILTER_LEN == 3 && $changed(filt_q[3]) |-> $past(line_src[3], 3) == filt_q[3])
        else $error("Filter passed a level too early");

    // Detectors
    AST_RISE_DETECT: assert property (
        !mode_sel[0] && edge_sel[0] && det_in[0] && !det_prev[0] |=> pending_flags[0])
        else $error("Rising edge not flagged");
    AST_FALL_DETECT: assert property (
        !mode_sel[0] && !edge_sel[0] && !det_in[0] && det_prev[0] |=> pending_flags[0])
        else $error("Falling edge not flagged");
    AST_EDGE_QUIET: assert property (
        !mode_sel[0] && det_in[0] == det_prev[0] |-> !event_hit[0])
        else $error("Edge mode fired without an edge");
    AST_LEVEL_HIGH: assert property (
        mode_sel[0] && level_sel[0] && det_in[0] |=> pending_flags[0])
        else $error("High level not flagged");
    AST_LEVEL_LOW: assert property (
        mode_sel[2] && !level_sel[2] && !det_in[2] |=> pending_flags[2])
        else $error("Low level not flagged");
    AST_NMI_LEVEL: assert property (
        mode_sel[8] && level_sel[8] && det_in[8] |=> pending_flags[8])
        else $error("NMI level not flagged");

    // Keypad scan
    AST_SCAN_IDLE: assert property (
        !sweep_on ##1 !sweep_on |=> active_sweep_index == 3'h0 && scan_pins_o == 8'h00)
        else $error("Scan engine active while disabled");
    AST_SCAN_WRAP: assert property (
        scan_step && active_sweep_index == 3'h7 |=> active_sweep_index == 3'h0)
        else $error("Scan index did not wrap");
    AST_SCAN_PINS: assert property (
        scan_state == eil_pkg::SCAN_RUN |=> scan_pins_o == (8'h01 << $past(active_sweep_index)))
        else $error("Scan pins do not match the index");
    AST_INDEX_RO: assert property (
        wr_sweep && !scan_step && scan_state == eil_pkg::SCAN_RUN
        |=> active_sweep_index == $past(active_sweep_index))
        else $error("Write moved the scan index");
    AST_SCAN_PERIOD: assert property (
        (scan_step && sweep_on && !wr_sweep && sweep_prescale == 5'h01 && RC_DIV == 1)
        ##1 (!wr_sweep [*3]) |=> scan_step)
        else $error("Scan step period wrong");

    COV_IRQ: cover property (wr_arm ##[1:20] irq_o);
    COV_SCAN_WRAP: cover property (scan_step && active_sweep_index == 3'h7);
    COV_OVERRIDE_EVENT: cover property (override_mode_on && event_hit[eil_pkg::NMI_BIT]);
    COV_FALL_EVENT: cover property (!mode_sel[0] && !edge_sel[0] && event_hit[0]);
    COV_LEVEL_EVENT: cover property (mode_sel[2] && event_hit[2]);
endmodule : eil_ctrl

// file: tb/eil_pad_model.sv
// Pad side model: drives the nine line pads one clock edge after each request
`timescale 1ns/10ps
module eil_pad_model (
    input wire logic ref_clk_i,
    input wire logic [8:0] level_req_i,
    output logic [7:0] ext_line_n_o,
    output logic nonmaskable_line_o
);
    always_ff @(posedge ref_clk_i) begin
        ext_line_n_o <= level_req_i[7:0];
        nonmaskable_line_o <= level_req_i[8];
    end
endmodule : eil_pad_model

// file: tb/eil_ctrl_tb.sv
// Self-checking bench for the external interrupt line controller
`timescale 1ns/10ps
module eil_ctrl_tb;
    typedef struct {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] ex;
    } eil_row_type;
    localparam int RC = 1;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [8:0] pads = 9'h000;
    logic [7:0] ext_n;
    logic nmi;
    logic [7:0] scan;
    logic irq;
    logic [31:0] d;
    logic [7:0] prev;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int n1;
    int n2;
    eil_row_type rows [20] = '{
        '{8'h14, 32'hffffffff, 8'h14, 32'h000001ff}, '{8'h18, 32'hffffffff, 8'h18, 32'h000001ff},
        '{8'h1c, 32'hffffffff, 8'h1c, 32'h000001ff}, '{8'h20, 32'hffffffff, 8'h20, 32'h000001ff},
        '{8'h28, 32'hffffffff, 8'h28, 32'h000001ff}, '{8'h24, 32'hffffffff, 8'h24, 32'h800001ff},
        '{8'h2c, 32'h07001f00, 8'h2c, 32'h00001f00}, '{8'h30, 32'h00000101, 8'h38, 32'h00000101},
        '{8'h34, 32'h00000001, 8'h38, 32'h00000100}, '{8'h30, 32'h000000fe, 8'h38, 32'h000001fe},
        '{8'h38, 32'hffffffff, 8'h38, 32'h000001fe}, '{8'h3c, 32'hffffffff, 8'h3c, 32'h00000000},
        '{8'h10, 32'h00000000, 8'h30, 32'h00000000}, '{8'h24, 32'h00000000, 8'h24, 32'h00000000},
        '{8'h14, 32'h00000000, 8'h14, 32'h00000000}, '{8'h18, 32'h00000000, 8'h18, 32'h00000000},
        '{8'h1c, 32'h00000000, 8'h1c, 32'h00000000}, '{8'h20, 32'h00000000, 8'h20, 32'h00000000},
        '{8'h2c, 32'h00000000, 8'h0c, 32'h000001ff}, '{8'h10, 32'h000001ff, 8'h0c, 32'h00000000}
    };

    eil_ctrl #(.FILTER_LEN(3), .RC_DIV(RC)) u_eil_ctrl (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .wr_data_i(wdata),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .ext_line_n_i(ext_n),
        .nonmaskable_line_i(nmi), .scan_pins_o(scan), .irq_o(irq)
    );
    eil_pad_model u_eil_pad_model (
        .ref_clk_i(ref_clk_i), .level_req_i(pads), .ext_line_n_o(ext_n), .nonmaskable_line_o(nmi)
    );

    always #10 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task check(input string what, input logic [31:0] ex, input logic [31:0] got);
        checked = checked + 1;
        if (got !== ex) begin
            n_errors = n_errors + 1;
            $display("BAD %s expected %h seen %h", what, ex, got);
        end
    endtask : check

    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge ref_clk_i);
    endtask : rd_reg

    task lat(input int l, input logic v, output int n);
        pads[l] <= v;
        n = 0;
        while (irq !== 1'b1 && n < 60) begin
            @(posedge ref_clk_i);
            #1 n = n + 1;
        end
    endtask : lat

    task step(output int n);
        prev = scan;
        n = 0;
        while (scan === prev && n < 200) begin
            @(posedge ref_clk_i);
            #1 n = n + 1;
        end
    endtask : step

    task print_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        foreach (rows[i]) begin
            wr_reg(rows[i].wa, rows[i].wd);
            rd_reg(rows[i].ra, d);
            check("register row", rows[i].ex, d);
        end
        // Edge detection, sync stage latency
        wr_reg(8'h30, 32'h000001ff);
        wr_reg(8'h18, 32'h000001ff);
        lat(0, 1'b1, n1);
        rd_reg(8'h0c, d);
        check("rising edge pending", 32'h00000001, d);
        wr_reg(8'h10, 32'h00000001);
        check("irq after clear", 32'h0, {31'h0, irq});
        wr_reg(8'h28, 32'h00000000);
        lat(1, 1'b1, n2);
        check("sync stage latency", n1 + 1, n2);
        wr_reg(8'h18, 32'h00000000);
        wr_reg(8'h10, 32'h000001ff);
        lat(0, 1'b0, n1);
        rd_reg(8'h0c, d);
        check("falling edge pending", 32'h00000001, d);
        // Level mode re-sets while the level persists
        wr_reg(8'h18, 32'h000001ff);
        pads[1] <= 1'b0;
        wr_reg(8'h10, 32'h000001ff);
        wr_reg(8'h14, 32'h00000004);
        wr_reg(8'h10, 32'h00000004);
        repeat (10) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("low level re-set", 32'h00000004, d);
        wr_reg(8'h1c, 32'h00000004);
        wr_reg(8'h10, 32'h00000004);
        repeat (10) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("high level idle", 32'h00000000, d);
        wr_reg(8'h14, 32'h00000000);
        // Glitch filter on line 3 only
        wr_reg(8'h20, 32'h00000008);
        pads[4:3] <= 2'b11;
        repeat (2) @(posedge ref_clk_i);
        pads[4:3] <= 2'b00;
        repeat (20) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("short pulse", 32'h00000010, d);
        pads[3] <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("long pulse", 32'h00000018, d);
        wr_reg(8'h10, 32'h000001ff);
        // Override feeds the detectors, pads ignored
        wr_reg(8'h24, 32'h80000100);
        pads[5] <= 1'b1;
        repeat (20) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("override value", 32'h00000100, d);
        wr_reg(8'h24, 32'h00000000);
        repeat (20) @(posedge ref_clk_i);
        rd_reg(8'h0c, d);
        check("pads back", 32'h00000128, d);
        wr_reg(8'h10, 32'h000001ff);
        // Keypad scan
        check("scan idle", 32'h0, {24'h0, scan});
        wr_reg(8'h2c, 32'h00000101);
        step(n1);
        for (int k = 0; k < 9; k++) begin
            step(n1);
            check("scan period", (2 ** 2) * RC, n1);
            check("scan pin", {24'h0, prev[6:0], prev[7]}, {24'h0, scan});
        end
        wr_reg(8'h2c, 32'h00000000);
        repeat (4) @(posedge ref_clk_i);
        check("scan stopped", 32'h0, {24'h0, scan});
        // Second reset in mid-run
        pads <= 9'h000;
        reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        for (int a = 12; a <= 56; a += 4) begin
            rd_reg(a[7:0], d);
            check("reset value", 32'h00000000, d);
        end
        check("irq after reset", 32'h0, {31'h0, irq});
        print_verdict();
    end
endmodule : eil_ctrl_tb
